// ### hw/interrupt_control_register_logic.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
module interrupt_control_register_logic
  import irq_ctrl_pkg::*;
#(
  parameter int PORT_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Sources
  input wire logic timer_overflow_i,
  input wire logic ext_pin_event_i,
  input wire logic [PORT_W-1:0] upper_port_pins_i,
  input wire logic second_port_data_read_i,
  input wire logic peripheral_irq_i,
  // Core side
  output logic [PORT_W-1:0] upper_port_latch_o,
  output logic core_irq_o,
  output logic status_irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage and its edge-detect copy ext_prev feed any logic
  logic [PORT_W-1:0] pin_meta;
  logic [PORT_W-1:0] pin_sync;
  logic [PORT_W-1:0] next_pin_meta;
  logic [PORT_W-1:0] next_pin_sync;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic next_ext_meta;
  logic next_ext_sync;
  logic next_ext_prev;

  always_comb begin
    next_pin_meta = upper_port_pins_i;
    next_pin_sync = pin_meta;
    next_ext_meta = ext_pin_event_i;
    next_ext_sync = ext_meta;
    next_ext_prev = ext_sync;
  end

  // Reset to the idle low level, so release shows no false edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else if (clk_en_i) begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      ext_meta <= next_ext_meta;
      ext_sync <= next_ext_sync;
      ext_prev <= next_ext_prev;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[ADDR_W-1:2];
    // Same physical register in every bank
    is_ctrl = (idx == INTERRUPT_CONTROL_IDX_BANK0) ||
              (idx == INTERRUPT_CONTROL_IDX_BANK1) ||
              (idx == INTERRUPT_CONTROL_IDX_BANK2) ||
              (idx == INTERRUPT_CONTROL_IDX_BANK3);
  endfunction

  logic [9:0] idx;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic hit_port;
  logic mapped;
  logic wr;
  logic rd;

  assign idx = adr_i[ADDR_W-1:2];
  assign req = cyc_i && stb_i && !ack_o && !err_o && clk_en_i;
  assign hit_ctrl = is_ctrl(adr_i);
  assign hit_stat = (idx == IRQ_STATUS_IDX);
  assign hit_mask = (idx == IRQ_MASK_IDX);
  assign hit_port = (idx == PORT_CTRL_IDX);
  assign mapped = hit_ctrl || hit_stat || hit_mask || hit_port;
  assign wr = req && mapped && we_i && sel_i[0];
  assign rd = req && mapped && !we_i;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] interrupt_control;
  logic [7:0] next_interrupt_control;
  logic [PORT_W-1:0] upper_port_dir;
  logic [PORT_W-1:0] next_upper_port_dir;
  logic [PORT_W-1:0] upper_port_latch;
  logic [PORT_W-1:0] next_upper_port_latch;
  logic [2:0] irq_status;
  logic [2:0] next_irq_status;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_mask;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_err;

  // ----------------------------------------------------------------
  // Source events
  // ----------------------------------------------------------------
  logic mismatch;
  logic ext_edge;
  logic [2:0] events;

  // Inputs only; output-direction pins never see a change
  assign mismatch = |((pin_sync ^ upper_port_latch) & upper_port_dir);
  // Rising edge only; a held pin is one event
  assign ext_edge = ext_sync && !ext_prev;
  assign events = {timer_overflow_i, ext_edge, mismatch};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    next_interrupt_control = interrupt_control;
    if (wr && hit_ctrl) begin
      next_interrupt_control = dat_i[7:0];
    end
    // Set after clear: an event in the clearing cycle is kept
    if (events[2]) begin
      next_interrupt_control[TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (events[1]) begin
      next_interrupt_control[EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
    end
    // Re-set every cycle while the mismatch lasts
    if (events[0]) begin
      next_interrupt_control[PORT_CHANGE_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      interrupt_control <= INTERRUPT_CONTROL_RESET;
    end else if (clk_en_i) begin
      interrupt_control <= next_interrupt_control;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status and mask
  // ----------------------------------------------------------------
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr && hit_mask) begin
      next_irq_mask = dat_i[2:0];
    end
    // Read clears, but an event in that cycle is not lost
    if (rd && hit_stat) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status <= IRQ_STATUS_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (clk_en_i) begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Port direction and read latch
  // ----------------------------------------------------------------
  always_comb begin
    next_upper_port_dir = upper_port_dir;
    next_upper_port_latch = upper_port_latch;
    if (wr && hit_port) begin
      next_upper_port_dir = dat_i[PORT_W-1:0];
    end
    // Port read re-arms the comparison
    if (second_port_data_read_i) begin
      next_upper_port_latch = pin_sync;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      upper_port_dir <= UPPER_PORT_DIR_RESET;
      upper_port_latch <= '0;
    end else if (clk_en_i) begin
      upper_port_dir <= next_upper_port_dir;
      upper_port_latch <= next_upper_port_latch;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer and read data
  // ----------------------------------------------------------------
  // Registered answer costs a cycle but keeps decode off the outputs
  always_comb begin
    next_dat = '0;
    next_ack = 1'b0;
    next_err = 1'b0;
    if (req) begin
      next_ack = mapped;
      next_err = !mapped;
    end
    if (rd) begin
      unique case (1'b1)
        hit_ctrl: next_dat[7:0] = interrupt_control;
        hit_stat: next_dat[2:0] = irq_status;
        hit_mask: next_dat[2:0] = irq_mask;
        hit_port: next_dat[PORT_W-1:0] = upper_port_dir;
        default: next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else if (clk_en_i) begin
      dat_o <= next_dat;
      ack_o <= next_ack;
      err_o <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------
  logic local_req;
  logic periph_req;

  assign local_req =
    (interrupt_control[TIMER_OVERFLOW_IRQ_ENABLE_BIT] &&
     interrupt_control[TIMER_OVERFLOW_FLAG_BIT]) ||
    (interrupt_control[EXT_PIN_IRQ_ENABLE_BIT] &&
     interrupt_control[EXT_PIN_IRQ_FLAG_BIT]) ||
    (interrupt_control[PORT_CHANGE_IRQ_ENABLE_BIT] &&
     interrupt_control[PORT_CHANGE_FLAG_BIT]);
  assign periph_req = peripheral_irq_i &&
    interrupt_control[PERIPHERAL_IRQ_ENABLE_BIT];
  assign core_irq_o = interrupt_control[GLOBAL_IRQ_ENABLE_BIT] &&
    (local_req || periph_req);
  assign status_irq_o = |(irq_status & irq_mask);
  assign upper_port_latch_o = upper_port_latch;

endmodule // interrupt_control_register_logic

// ### hw/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map (word indexes; byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [9:0] INTERRUPT_CONTROL_IDX_BANK0 = 10'h00B;
  localparam logic [9:0] INTERRUPT_CONTROL_IDX_BANK1 = 10'h08B;
  localparam logic [9:0] INTERRUPT_CONTROL_IDX_BANK2 = 10'h10B;
  localparam logic [9:0] INTERRUPT_CONTROL_IDX_BANK3 = 10'h18B;
  localparam logic [9:0] IRQ_STATUS_IDX = 10'h200;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h201;
  localparam logic [9:0] PORT_CTRL_IDX = 10'h202;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Field positions of interrupt_control
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
  localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
  localparam int PORT_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
  localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
  localparam int PORT_CHANGE_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [3:0] UPPER_PORT_DIR_RESET = 4'hF;

  // ----------------------------------------------------------------
  // Event bundle from the sources
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer_overflow;
    logic ext_pin;
    logic port_read;
  } source_events_s;

endpackage

// ### tb/interrupt_control_register_logic_asserts.sv
`timescale 1ns/10ps
// ---
// Port checker
// ---
module irq_ctrl_asserts
  import irq_ctrl_pkg::*;
#(parameter int PORT_W = 4) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic ext_pin_event_i,
  input wire logic timer_overflow_i,
  input wire logic second_port_data_read_i,
  input wire logic peripheral_irq_i,
  input wire logic [PORT_W-1:0] upper_port_latch_o,
  input wire logic core_irq_o
);
  // Shadow of the software enables; flags are hardware-set
  logic [7:0] ctl;
  wire [9:0] ix = adr_i[11:2];
  wire tk = cyc_i && stb_i && !ack_o && !err_o && clk_en_i;
  wire isc = !ix[9] && ix[6:0] == 7'h0B;
  wire map = isc || ix inside {IRQ_STATUS_IDX, IRQ_MASK_IDX, PORT_CTRL_IDX};
  always_ff @(posedge sys_clk_i)
    if (rst_i) ctl <= 8'h00;
    else if (tk && we_i && sel_i[0] && isc) ctl <= dat_i[7:0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  bus_answer_a: assert property (tk |=> (ack_o ^ err_o) && err_o == !map)
    else $error("wrong bus answer");
  gie_gate_a: assert property (!ctl[7] |-> !core_irq_o)
    else $error("request with global enable clear");
  timer_irq_a: assert property (timer_overflow_i && ctl[7] && ctl[5]
    |=> core_irq_o || !(ctl[7] && ctl[5])) else $error("no timer request");
  ext_irq_a: assert property ($rose(ext_pin_event_i) && ctl[7] && ctl[4]
    |-> ##[1:4] core_irq_o) else $error("no pin request");
  periph_irq_a: assert property ((peripheral_irq_i && ctl[7] && ctl[6])[*2]
    |-> core_irq_o) else $error("no peripheral request");
  latch_hold_a: assert property (!second_port_data_read_i && clk_en_i
    |=> $stable(upper_port_latch_o)) else $error("latch moved");
  byte_read_a: assert property (!ack_o || dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule // irq_ctrl_asserts

bind interrupt_control_register_logic irq_ctrl_asserts #(.PORT_W(PORT_W)) u_chk (.*);

// ### tb/irq_src_model.sv
`timescale 1ns/10ps
// ---
// Timer and port pins as seen by the block
// ---
module irq_src_model (
  input wire logic sys_clk_i,
  input wire logic tick_i,
  input wire logic [3:0] pins_i,
  output logic timer_overflow_o = 1'b0,
  output logic [3:0] pins_o = 4'h0
);
  logic tick_q = 1'b0;
  // One pulse per request, so a held tick is one roll-over
  always @(posedge sys_clk_i) begin
    tick_q <= tick_i;
    timer_overflow_o <= tick_i & !tick_q;
    pins_o <= pins_i;
  end
endmodule // irq_src_model

// ### tb/test_interrupt_control_register_logic.sv
`timescale 1ns/10ps
module test_interrupt_control_register_logic;
  import irq_ctrl_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0, ext = 0;
  logic prd = 0, pirq = 0, en = 1, ack, err, irq, sirq, tmr, e;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0, pq = 4'h0, pins, latch;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [7:0] v;
  int n_mismatch = 0, n_compared = 0, cyc_cnt = 0;
  interrupt_control_register_logic u_interrupt_control_register_logic (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(en), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .err_o(err), .timer_overflow_i(tmr),
    .ext_pin_event_i(ext), .upper_port_pins_i(pins),
    .second_port_data_read_i(prd), .peripheral_irq_i(pirq),
    .upper_port_latch_o(latch), .core_irq_o(irq), .status_irq_o(sirq));
  irq_src_model u_irq_src_model (.sys_clk_i(sys_clk_i), .tick_i(tick),
    .pins_i(pq), .timer_overflow_o(tmr), .pins_o(pins));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, 24'h0, d};
    @(posedge sys_clk_i);
    while (!(ack | err)) @(posedge sys_clk_i);
    q = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk_i);
  endtask
  function automatic logic [11:0] ca(input int k);
    return {1'b0, k[1:0], 7'h0B, 2'b00};
  endfunction
  function automatic logic xirq(input logic [7:0] c, input logic p);
    return c[7] & (c[5] & c[2] | c[4] & c[1] | c[3] & c[0] | c[6] & p);
  endfunction
  task automatic cyc_n(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  initial begin
    void'($urandom(96));
    cyc_n(4);
    rst_i <= 0;
    cyc_n(1);
    for (int k = 0; k < 4; k++) begin
      wb(0, ca(k), 0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      pirq <= v[6] ^ v[0];
      wb(1, ca(i), v);
      wb(0, ca(i + 1), 0);
      chk(q, {24'h0, v});
      chk(irq, xirq(v, v[6] ^ v[0]));
    end
    wb(0, 12'hFFC, 0);
    chk(e, 1'b1);
    wb(1, {IRQ_MASK_IDX, 2'b00}, 8'h04);
    foreach (v[b]) if (b == 5 || b == 7) begin
      wb(1, ca(0), 8'h00);
      wb(1, ca(0), b == 7 ? 8'hA0 : 8'h20);
      tick <= 1;
      cyc_n(1);
      tick <= 0;
      cyc_n(3);
      wb(0, ca(3), 0);
      chk(q, b == 7 ? 32'hA4 : 32'h24);
      chk(irq, b == 7);
      chk(sirq, 1'b1);
    end
    wb(0, {IRQ_STATUS_IDX, 2'b00}, 0);
    chk(q, 32'h4);
    chk(sirq, 1'b0);
    wb(1, ca(0), 8'h90);
    ext <= 1;
    cyc_n(5);
    wb(0, ca(1), 0);
    chk(q, 32'h92);
    chk({irq, sirq}, 2'b10);
    wb(1, ca(0), 8'h00);
    pq <= 4'h5;
    cyc_n(4);
    wb(1, ca(0), 8'h00);
    wb(0, ca(2), 0);
    chk(q, 32'h01);
    prd <= 1;
    cyc_n(1);
    prd <= 0;
    cyc_n(2);
    chk(latch, 4'h5);
    wb(1, ca(0), 8'h00);
    wb(1, {PORT_CTRL_IDX, 2'b00}, 8'h00);
    pq <= 4'hA;
    cyc_n(4);
    wb(0, ca(0), 0);
    chk(q, 32'h0);
    // Frozen clock: a roll-over in that time is not seen
    en <= 0;
    tick <= 1;
    cyc_n(1);
    tick <= 0;
    cyc_n(3);
    en <= 1;
    cyc_n(1);
    wb(0, ca(0), 0);
    chk(q, 32'h0);
    test_done();
  end
endmodule // test_interrupt_control_register_logic
